//--- design/gdf_device.sv
// Device end: fault latch, enable control and interlock of the gate driver
// How it works
// - Flags only pull low or release
// - Undriven reset/enable reads low, driver off
// - Reset/enable high enables, low disables output
// - Overcurrent latches fault low, gate off
// - Reset/enable ignored during fault mute interval
// - Host must reset after fault to recover
// - Host holds clear low minimum time after mute
// - Host ties non-inverted PWM to reset/enable in auto reset
// - PWM on reset/enable clears fault each cycle
// - PWM off-time exceeds minimum clear time
// - Both PWM inputs high forces gate low
// - Pulses under deglitch interval rejected
`timescale 1ns/1ps
module gdf_device
    import gdf_pkg::*;
#(
    parameter int MUTE_CYC = FAULT_MUTE_CYC,
    parameter int CLEAR_CYC = CLEAR_PULSE_MIN_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Pins toward host
    gdf_if.device pins,
    // Power stage side
    input wire logic overcurrent_sense,
    input wire logic supply_ok,
    output logic gate_source_output,
    output logic gate_sink_output
);
    // ------------------------------------------------------------
    // Input filtering
    // ------------------------------------------------------------
    logic pos_f;
    logic neg_f;
    logic en_f;
    logic oc_s1_reg;
    logic oc_s2_reg;
    logic sup_s1_reg;
    logic sup_s2_reg;

    gdf_deglitch u_pos (.core_clk(core_clk), .reset(reset), .pin_in(pins.pwm_pos),
        .level_out(pos_f));
    gdf_deglitch u_neg (.core_clk(core_clk), .reset(reset), .pin_in(pins.pwm_neg),
        .level_out(neg_f));
    // filter resets low, so an undriven pin reads as disabled
    gdf_deglitch u_en (.core_clk(core_clk), .reset(reset), .pin_in(pins.reset_enable_n),
        .level_out(en_f));

    // ------------------------------------------------------------
    // Fault state machine
    // ------------------------------------------------------------
    gdf_state_t state_reg;
    gdf_state_t state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic clear_low_reg;
    logic clear_low_next;
    logic mute_done;
    logic clear_done;
    logic drive_on;

    assign mute_done = cnt_reg >= CNT_W'(MUTE_CYC - 1);
    assign clear_done = cnt_reg >= CNT_W'(CLEAR_CYC - 1);

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        clear_low_next = clear_low_reg;
        unique case (state_reg)
            GDF_DISABLED: begin
                if (en_f) begin
                    state_next = GDF_RUN;
                end
            end
            GDF_RUN: begin
                if (oc_s2_reg) begin
                    state_next = GDF_MUTE;
                    cnt_next = '0;
                end else if (!en_f) begin
                    state_next = GDF_DISABLED;
                end
            end
            GDF_MUTE: begin
                cnt_next = cnt_reg + CNT_W'(1);
                if (mute_done) begin
                    state_next = GDF_LATCHED;
                    cnt_next = '0;
                    clear_low_next = 1'b0;
                end
            end
            GDF_LATCHED: begin
                // any qualifying low pulse clears, PWM-driven or not
                if (!en_f) begin
                    if (!clear_done) begin
                        cnt_next = cnt_reg + CNT_W'(1);
                    end else begin
                        clear_low_next = 1'b1;
                    end
                end else begin
                    cnt_next = '0;
                    // release on return high after qualifying pulse
                    if (clear_low_reg) begin
                        state_next = GDF_RUN;
                        clear_low_next = 1'b0;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_reg <= GDF_DISABLED;
            cnt_reg <= '0;
            clear_low_reg <= 1'b0;
            oc_s1_reg <= 1'b0;
            oc_s2_reg <= 1'b0;
            sup_s1_reg <= 1'b0;
            sup_s2_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            clear_low_reg <= clear_low_next;
            oc_s1_reg <= overcurrent_sense;
            oc_s2_reg <= oc_s1_reg;
            sup_s1_reg <= supply_ok;
            sup_s2_reg <= sup_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic fault_low;
    logic src_reg;
    logic flt_oe_reg;
    logic rdy_oe_reg;

    assign fault_low = (state_next == GDF_MUTE) || (state_next == GDF_LATCHED);
    // interlock: both inputs high forces output low
    // output only while enabled and not faulted, off on fault
    assign drive_on = (state_next == GDF_RUN) && en_f && pos_f && !neg_f && sup_s2_reg;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            src_reg <= 1'b0;
            flt_oe_reg <= 1'b0;
            rdy_oe_reg <= 1'b1;
        end else begin
            src_reg <= drive_on;
            flt_oe_reg <= fault_low;
            rdy_oe_reg <= !sup_s2_reg;
        end
    end

    assign gate_source_output = src_reg;
    assign gate_sink_output = !src_reg;
    assign pins.fault_flag_n_oe = flt_oe_reg;
    assign pins.supply_good_oe = rdy_oe_reg;
endmodule : gdf_device

//--- pkg/gdf_pkg.sv
// Package: constants and types shared by the gate driver fault control ends
package gdf_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    // Deglitch interval in ns; shorter pulses are rejected
    localparam int DEGLITCH_NS = 40;
    localparam int DEGLITCH_CYC = (DEGLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Fault mute interval in ns (plain default)
    localparam int FAULT_MUTE_NS = 10000;
    localparam int FAULT_MUTE_CYC = (FAULT_MUTE_NS * 1000) / CLK_PERIOD_PS;
    // Minimum clear pulse time in ns (plain default)
    localparam int CLEAR_PULSE_MIN_NS = 1000;
    localparam int CLEAR_PULSE_MIN_CYC =
        (CLEAR_PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RST_LEVEL_IN = 1'b0;

    // ------------------------------------------------------------
    // Device states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        GDF_DISABLED = 2'b00,
        GDF_RUN = 2'b01,
        GDF_MUTE = 2'b10,
        GDF_LATCHED = 2'b11
    } gdf_state_t;

endpackage : gdf_pkg

//--- pkg/gdf_if.sv
// Interface: pins between host controller and gate driver
`timescale 1ns/1ps
interface gdf_if;
    // PWM and reset/enable, driven by host
    logic pwm_pos;
    logic pwm_neg;
    logic reset_enable_n;
    // Open-drain flags: pull low enable from device
    logic fault_flag_n_oe;
    logic supply_good_oe;
    // Wire levels resolved by the testbench from enables and pull-ups
    logic fault_flag_n;
    logic supply_good;

    modport device (
        input pwm_pos,
        input pwm_neg,
        input reset_enable_n,
        output fault_flag_n_oe,
        output supply_good_oe
    );

    modport host (
        output pwm_pos,
        output pwm_neg,
        output reset_enable_n,
        input fault_flag_n,
        input supply_good
    );
endinterface : gdf_if

//--- design/gdf_deglitch.sv
// Synchroniser and deglitch filter for one pin input
`timescale 1ns/1ps
module gdf_deglitch
    import gdf_pkg::*;
#(
    parameter int STABLE_CYC = DEGLITCH_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Pin and filtered level
    input wire logic pin_in,
    output logic level_out
);
    logic sync1_reg;
    logic sync2_reg;
    logic [CNT_W-1:0] stable_reg;
    logic [CNT_W-1:0] stable_next;
    logic differs;
    logic settled;

    assign differs = sync2_reg != level_out;
    assign settled = differs && (stable_reg >= CNT_W'(STABLE_CYC - 1));
    assign stable_next = differs ? stable_reg + CNT_W'(1) : '0;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sync1_reg <= RST_LEVEL_IN;
            sync2_reg <= RST_LEVEL_IN;
            stable_reg <= '0;
            level_out <= RST_LEVEL_IN;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            stable_reg <= settled ? '0 : stable_next;
            if (settled) begin
                level_out <= sync2_reg;
            end
        end
    end
endmodule : gdf_deglitch

//--- design/gdf_host.sv
// Host end: drives PWM and reset/enable, clears faults, reads flags
`timescale 1ns/1ps
module gdf_host
    import gdf_pkg::*;
#(
    parameter int MUTE_CYC = FAULT_MUTE_CYC,
    parameter int CLEAR_CYC = CLEAR_PULSE_MIN_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Pins toward device
    gdf_if.host pins,
    // User side
    input wire logic pwm_cmd,
    input wire logic use_inverting,
    input wire logic auto_reset,
    input wire logic enable_cmd,
    output logic fault_seen,
    output logic supply_good_seen
);
    logic flt_s1_reg;
    logic flt_s2_reg;
    logic flt_s3_reg;
    logic rdy_s1_reg;
    logic rdy_s2_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic clearing_reg;
    logic low_phase;
    logic pos_reg;
    logic neg_reg;
    logic en_reg;
    logic en_next;
    logic pwm_en;
    logic fault_edge;

    // mute wait then minimum low pulse
    assign low_phase = cnt_reg >= CNT_W'(MUTE_CYC);
    // auto reset uses non-inverted PWM on reset/enable
    assign pwm_en = pwm_cmd;
    // new fault only: a flag still low after a clear must not restart it
    assign fault_edge = flt_s3_reg && !flt_s2_reg;
    assign en_next = auto_reset ? pwm_en : (enable_cmd && !(clearing_reg && low_phase));

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            flt_s1_reg <= 1'b1;
            flt_s2_reg <= 1'b1;
            flt_s3_reg <= 1'b1;
            rdy_s1_reg <= 1'b0;
            rdy_s2_reg <= 1'b0;
            cnt_reg <= '0;
            clearing_reg <= 1'b0;
            pos_reg <= 1'b0;
            neg_reg <= 1'b0;
            en_reg <= 1'b0;
        end else begin
            flt_s1_reg <= pins.fault_flag_n;
            flt_s2_reg <= flt_s1_reg;
            flt_s3_reg <= flt_s2_reg;
            rdy_s1_reg <= pins.supply_good;
            rdy_s2_reg <= rdy_s1_reg;
            pos_reg <= use_inverting ? 1'b1 : pwm_cmd;
            neg_reg <= use_inverting ? !pwm_cmd : 1'b0;
            en_reg <= en_next;
            if (!clearing_reg) begin
                clearing_reg <= fault_edge && !auto_reset;
                cnt_reg <= '0;
            end else if (cnt_reg >= CNT_W'(MUTE_CYC + CLEAR_CYC + 2)) begin
                clearing_reg <= 1'b0;
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + CNT_W'(1);
            end
        end
    end

    assign pins.pwm_pos = pos_reg;
    assign pins.pwm_neg = neg_reg;
    assign pins.reset_enable_n = en_reg;
    assign fault_seen = !flt_s2_reg;
    assign supply_good_seen = rdy_s2_reg;
endmodule : gdf_host

//--- test/gdf_monitor.sv
// Checker on the pins between host and gate driver
`timescale 1ns/1ps
module gdf_monitor
    import gdf_pkg::*;
#(
    parameter int MUTE_CYC = FAULT_MUTE_CYC,
    parameter int CLEAR_CYC = CLEAR_PULSE_MIN_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Host pins
    input wire logic pwm_pos,
    input wire logic pwm_neg,
    input wire logic reset_enable_n,
    // Flag pins
    input wire logic fault_flag_n_oe,
    input wire logic supply_good_oe,
    input wire logic fault_flag_n,
    input wire logic supply_good,
    // Power stage
    input wire logic overcurrent_sense,
    input wire logic gate_source_output,
    input wire logic gate_sink_output
);
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    int unsigned flt_cnt_reg;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // Length of the current fault hold
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            flt_cnt_reg <= 0;
        end else begin
            flt_cnt_reg <= fault_flag_n_oe ? flt_cnt_reg + 1 : 0;
        end
    end
    sequence s_oc_hit;
        gate_source_output && $rose(overcurrent_sense) ##1 overcurrent_sense[*3];
    endsequence
    sequence s_flt_held;
        fault_flag_n_oe ##1 fault_flag_n_oe;
    endsequence
    a_flag_wire: assert property (
        fault_flag_n == !fault_flag_n_oe && supply_good == !supply_good_oe)
        else $error("flag wire not open drain");
    a_sink_pair: assert property (
        gate_sink_output == !gate_source_output)
        else $error("gate outputs not complementary");
    a_disable_gate: assert property (
        (!reset_enable_n)[*8] |-> ##2 !gate_source_output)
        else $error("gate on while disabled");
    a_shoot_lock: assert property (
        (pwm_pos && pwm_neg)[*8] |-> ##2 !gate_source_output)
        else $error("gate on with both inputs high");
    a_oc_latch: assert property (
        s_oc_hit |-> ##[0:6] fault_flag_n_oe)
        else $error("overcurrent not latched");
    a_fault_gate: assert property (
        s_flt_held |-> !gate_source_output)
        else $error("gate on during fault");
    a_mute_hold: assert property (
        $fell(fault_flag_n_oe) |-> flt_cnt_reg >= MUTE_CYC + CLEAR_CYC)
        else $error("fault released too early");
    a_release_high: assert property (
        $fell(fault_flag_n_oe) |-> $past(reset_enable_n, 2) && $past(reset_enable_n))
        else $error("fault released without enable high");
    a_flag_idle: assert property (
        (!fault_flag_n_oe && !overcurrent_sense)[*8] |=> !fault_flag_n_oe)
        else $error("fault raised without overcurrent");
endmodule : gdf_monitor

//--- test/gate_driver_fault_enable_ctrl_tb.sv
// Testbench joining host and device ends of the gate driver control
`timescale 1ns/1ps
module gate_driver_fault_enable_ctrl_tb;
    import gdf_pkg::*;
    localparam int MUTE = 20;
    localparam int CLEAR = 8;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic pwm_cmd = 1'b0, use_inverting = 1'b0, auto_reset = 1'b0, enable_cmd = 1'b0;
    logic overcurrent_sense = 1'b0, supply_ok = 1'b1;
    logic gate_source_output, gate_sink_output, fault_seen, supply_good_seen;
    logic [31:0] lfsr = 32'h00016a3a;
    int error_cnt = 0, num_checks = 0;
    gdf_if gif();
    // Pull-ups on both flag wires
    assign gif.fault_flag_n = gif.fault_flag_n_oe ? 1'b0 : 1'b1;
    assign gif.supply_good = gif.supply_good_oe ? 1'b0 : 1'b1;
    gdf_device #(.MUTE_CYC(MUTE), .CLEAR_CYC(CLEAR)) gdf_device_inst (
        .core_clk(core_clk), .reset(reset), .pins(gif.device),
        .overcurrent_sense(overcurrent_sense), .supply_ok(supply_ok),
        .gate_source_output(gate_source_output), .gate_sink_output(gate_sink_output));
    gdf_host #(.MUTE_CYC(MUTE), .CLEAR_CYC(CLEAR)) gdf_host_inst (
        .core_clk(core_clk), .reset(reset), .pins(gif.host), .pwm_cmd(pwm_cmd),
        .use_inverting(use_inverting), .auto_reset(auto_reset), .enable_cmd(enable_cmd),
        .fault_seen(fault_seen), .supply_good_seen(supply_good_seen));
    gdf_monitor #(.MUTE_CYC(MUTE), .CLEAR_CYC(CLEAR)) gdf_monitor_inst (
        .core_clk(core_clk), .reset(reset), .pwm_pos(gif.pwm_pos), .pwm_neg(gif.pwm_neg),
        .reset_enable_n(gif.reset_enable_n), .fault_flag_n_oe(gif.fault_flag_n_oe),
        .supply_good_oe(gif.supply_good_oe), .fault_flag_n(gif.fault_flag_n),
        .supply_good(gif.supply_good), .overcurrent_sense(overcurrent_sense),
        .gate_source_output(gate_source_output), .gate_sink_output(gate_sink_output));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    // Expected gate level from the commands: inverting mode holds pwm_pos high
    function automatic logic exp_gate(input logic pwm, input logic inv, input logic e);
        logic p;
        logic n;
        p = inv | pwm;
        n = inv & ~pwm;
        return p & ~n & e;
    endfunction : exp_gate
    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask : step
    task automatic chk(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_fault(input logic want);
        for (int i = 0; i < 300 && fault_seen !== want; i++) @(negedge core_clk);
    endtask : wait_fault
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        #(8 * 6000);
        error_cnt++;
        stop_test();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        step(2);
        chk(gif.reset_enable_n, 1'b0);
        chk(gate_source_output, 1'b0);
        $display("Test 1 done");
        for (int k = 0; k < 12; k++) begin
            lfsr = lfsr_next(lfsr);
            @(posedge core_clk);
            pwm_cmd <= lfsr[0];
            enable_cmd <= lfsr[1] | (k < 2);
            use_inverting <= lfsr[2] & (k > 3);
            step(20);
            chk(gate_source_output, exp_gate(pwm_cmd, use_inverting, enable_cmd));
        end
        $display("Test 2 done");
        @(posedge core_clk);
        use_inverting <= 1'b0;
        enable_cmd <= 1'b1;
        pwm_cmd <= 1'b0;
        step(20);
        @(posedge core_clk);
        pwm_cmd <= 1'b1;
        // Longest pulse that must still be rejected
        repeat (DEGLITCH_CYC - 1) @(posedge core_clk);
        pwm_cmd <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            step(1);
            chk(gate_source_output, 1'b0);
        end
        $display("Test 3 done");
        @(posedge core_clk);
        pwm_cmd <= 1'b1;
        step(20);
        @(posedge core_clk);
        overcurrent_sense <= 1'b1;
        step(4);
        @(posedge core_clk);
        overcurrent_sense <= 1'b0;
        wait_fault(1'b1);
        chk(fault_seen, 1'b1);
        chk(gate_source_output, 1'b0);
        wait_fault(1'b0);
        chk(fault_seen, 1'b0);
        step(20);
        chk(gate_source_output, 1'b1);
        $display("Test 4 done");
        @(posedge core_clk);
        auto_reset <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            @(posedge core_clk);
            pwm_cmd <= 1'b1;
            overcurrent_sense <= (k == 1);
            step(16);
            @(posedge core_clk);
            pwm_cmd <= 1'b0;
            overcurrent_sense <= 1'b0;
            step(20);
            if (k == 1) chk(fault_seen, 1'b1);
        end
        chk(fault_seen, 1'b0);
        $display("Test 5 done");
        @(posedge core_clk);
        supply_ok <= 1'b0;
        step(10);
        chk(supply_good_seen, 1'b0);
        @(posedge core_clk);
        supply_ok <= 1'b1;
        step(10);
        chk(supply_good_seen, 1'b1);
        $display("Test 6 done");
        stop_test();
    end
endmodule : gate_driver_fault_enable_ctrl_tb
